// ===== inc/tbs_pkg.sv
/*
 * Shared constants for the trace-buffer sync counter and integration-test
 * register bank: register offsets, field positions, reset values, widths.
 * Assumes a 12-bit APB byte address and 32-bit APB data.
 */
package tbs_pkg;

    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int ATB_DATA_W = 128;
    localparam int ATB_BYTES_W = 4;
    localparam int ATID_W = 7;
    localparam int CODE_W = 5;
    localparam int CNT_W = 28;             // Holds 2^27
    localparam int BCNT_W = 5;             // Bytes stored per cycle, 0..16
    localparam int DCAP_W = 1 + ATB_DATA_W / 8;

    // ----------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [ADDR_W-1:0] OFF_SPC = 12'h308;
    localparam logic [ADDR_W-1:0] OFF_EVT = 12'hEE0;
    localparam logic [ADDR_W-1:0] OFF_TFIN = 12'hEE8;
    localparam logic [ADDR_W-1:0] OFF_DATA = 12'hEEC;
    localparam logic [ADDR_W-1:0] OFF_ATBO = 12'hEF0;
    localparam logic [ADDR_W-1:0] OFF_ID = 12'hEF4;
    localparam logic [ADDR_W-1:0] OFF_ATBI = 12'hEF8;
    localparam logic [ADDR_W-1:0] OFF_IMC = 12'hF00;

    // ----------------------------------------
    // Sync period field values and reset
    // ----------------------------------------
    localparam logic [CODE_W-1:0] CODE_OFF = 5'h00;
    localparam logic [CODE_W-1:0] CODE_MIN = 5'h07;
    localparam logic [CODE_W-1:0] CODE_MAX = 5'h1B;
    localparam logic [CODE_W-1:0] CODE_RST = 5'h0A;
    localparam logic [DATA_W-1:0] SPC_RST = 32'h0000000A;
    localparam int SPC_FSI_BIT = 5;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int EVT_BUFINTR = 3;
    localparam int EVT_FLUSHCOMP = 2;
    localparam int EVT_FULL = 1;
    localparam int EVT_ACQCOMP = 0;
    localparam int ATBO_SYNCREQ = 2;
    localparam int ATBO_AFVALID = 1;
    localparam int ATBO_ATREADY = 0;
    localparam int TFIN_FLUSH = 1;
    localparam int TFIN_TRIG = 0;
    localparam int ATBI_BYTES_LSB = 8;
    localparam int ATBI_WAKEUP = 2;
    localparam int ATBI_AFREADY = 1;
    localparam int ATBI_ATVALID = 0;
    localparam int IMC_EN = 0;

    // Reserved codes fold onto the largest legal code
    function automatic logic [CODE_W-1:0] tbs_legal_code(input logic [CODE_W-1:0] c);
        if (c == CODE_OFF || (c >= CODE_MIN && c <= CODE_MAX)) begin
            return c;
        end
        return CODE_MAX;
    endfunction

    // Counter reload for a legal code: 2^code bytes
    function automatic logic [CNT_W-1:0] tbs_reload(input logic [CODE_W-1:0] c);
        return {{(CNT_W-1){1'b0}}, 1'b1} << c;
    endfunction

endpackage

// ===== inc/tbs_sync_if.sv
/*
 * Link between the register bank and the sync byte counter.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
interface tbs_sync_if;
    import tbs_pkg::*;
    logic capture_en;              // Trace capture enabled
    logic [CODE_W-1:0] code;       // Programmed period code
    logic [BCNT_W-1:0] bytes;      // Bytes stored this cycle
    logic expire;                  // One-cycle pulse: counter hit zero

    modport regs (output capture_en, output code, output bytes, input expire);
    modport cnt (input capture_en, input code, input bytes, output expire);
endinterface

// ===== verilog/tbs_sync_cnt.sv
/*
 * Periodic synchronization byte counter.
 * Assumes bytes reports what was written to trace memory this cycle, and
 * that the code it sees is already legal (0 or 7..27).
 */
`timescale 1ns/100ps
module tbs_sync_cnt
    import tbs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    tbs_sync_if.cnt sif
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [CNT_W-1:0] cnt;     // Bytes left until next request
        logic en_q;                // Capture enable last cycle
        logic expire;              // Expiry pulse
    } tbs_cnt_st_t;

    tbs_cnt_st_t st_r;
    tbs_cnt_st_t st_nxt;
    logic [CNT_W-1:0] bytes_w;     // Byte count widened to the counter

    assign bytes_w = {{(CNT_W-BCNT_W){1'b0}}, sif.bytes};
    assign sif.expire = st_r.expire;

    // Next-state: load, count down, reload on expiry
    always_comb begin
        st_nxt = st_r;
        st_nxt.en_q = sif.capture_en;
        st_nxt.expire = 1'b0;
        if (!sif.capture_en || sif.code == CODE_OFF) begin
            // Hold: capture off or sync disabled                 (R22)
            st_nxt.cnt = st_r.cnt;
        end else if (!st_r.en_q || st_r.cnt == '0) begin
            st_nxt.cnt = tbs_reload(sif.code);                 // R21
        end else if (bytes_w >= st_r.cnt) begin
            // While counting, a new code only takes effect here, at zero
            st_nxt.cnt = tbs_reload(sif.code);                 // R3
            st_nxt.expire = 1'b1;                              // R2
        end else begin
            st_nxt.cnt = st_r.cnt - bytes_w;                   // R1
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    cnt_decrement_a: assert property (@(posedge pclk) disable iff (!presetn) // R1
        (sif.capture_en && sif.code != CODE_OFF && st_r.en_q && st_r.cnt > bytes_w)
        |=> st_r.cnt == $past(st_r.cnt) - $past(bytes_w))
        else $error("counter did not drop by stored bytes");
    cnt_disabled_a: assert property (@(posedge pclk) disable iff (!presetn) // R22
        (sif.code == CODE_OFF) |=> !st_r.expire && $stable(st_r.cnt))
        else $error("counter moved while sync disabled");
    cnt_reload_c: cover property (@(posedge pclk) disable iff (!presetn)
        st_r.expire ##1 !st_r.expire);

endmodule // tbs_sync_cnt

// ===== verilog/tbs_regs.sv
/*
 * Trace-buffer sync period register and integration-test register bank,
 * reached over APB. Drives sync requests and frame sync inserts in normal
 * operation and lets software drive/observe pins in integration mode.
 * Assumes ATB and functional event signals come from logic on pclk;
 * trigin and flushin come from outside and are synchronised here.
 */
// Chosen here: the APB slave port.
//
// Operation
// (R1) Count down stored trace bytes while capturing
// (R2) Counter zero raises sync request upstream
// (R3) New period loads only at next zero
// (R4) Code zero disables; 7..27 gives 2^code
// (R5) Reserved codes stored as 0x1B
// (R6) Sync period register resets to 0x0A
// (R7) Read returns programmed value, not count
// (R8) Expiry with embed bit inserts frame sync
// (R9) Embed bit needs formatting active
// (R10) Test registers RAZ/WI outside integration mode
// (R11) Event test register drives event outputs
// (R12) ATB output test register drives ATB outputs
// (R13) Sticky bits catch trigin/flushin rising edges
// (R14) Sticky bits clear on read or exit
// (R15) Data capture returns selected atdata_s bits
// (R16) ID capture returns live atid_s
// (R17) Control capture returns live ATB controls
// (R18) Input capture writes ignored, reads live
// (R19) Mode control bit 0 enters integration
// (R20) Formatting on if formatter or trigger insert
// (R21) Counter loads period when capture starts
// (R22) Code zero: no counting, no requests
`timescale 1ns/100ps
module tbs_regs
    import tbs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Sink control from the formatter block
    input wire logic trace_capture_en,
    input wire logic formatter_en,
    input wire logic trigger_insert_en,
    input wire logic [BCNT_W-1:0] byte_store_cnt,
    output logic frame_sync_req,
    // Functional values of pins the test registers can take over
    input wire logic func_atready,
    input wire logic func_afvalid,
    input wire logic [3:0] func_evt,
    // ATB slave port
    input wire logic [ATB_DATA_W-1:0] atdata_s,
    input wire logic [ATID_W-1:0] atid_s,
    input wire logic [ATB_BYTES_W-1:0] atbytes_s,
    input wire logic atvalid_s,
    input wire logic afready_s,
    input wire logic atwakeup_s,
    output logic atready_s,
    output logic afvalid_s,
    output logic syncreq_s,
    // Event pins
    input wire logic trigin,
    input wire logic flushin,
    output logic bufintr,
    output logic flushcomp,
    output logic full,
    output logic acqcomp
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [CODE_W-1:0] code;   // Period code, always legal
        logic fsi;                 // Frame sync insert enable
        logic itmode;              // Integration mode
        logic [3:0] evt;           // Event test values
        logic [2:0] atbo;          // ATB output test values
        logic [1:0] tfin;          // Sticky flush/trigger bits
        logic [2:0] trig_s;        // Sync ff1, ff2, previous
        logic [2:0] flush_s;       // Sync ff1, ff2, previous
        logic pready;              // APB answer
        logic pslverr;             // APB error
        logic [DATA_W-1:0] prdata; // APB read data
        logic syncreq;             // Output flops
        logic afvalid;
        logic atready;
        logic [3:0] evt_out;
        logic frame_sync;
    } tbs_regs_st_t;

    tbs_regs_st_t st_r;
    tbs_regs_st_t st_nxt;

    tbs_sync_if sif ();

    // Reset image: period code at its default, all else clear
    localparam tbs_regs_st_t ST_RST = '{code: CODE_RST, default: '0}; // R6

    // ----------------------------------------
    // Helpers
    // ----------------------------------------

    // Mapped register check
    function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
        unique case (a)
            OFF_SPC, OFF_EVT, OFF_TFIN, OFF_DATA, OFF_ATBO,
            OFF_ID, OFF_ATBI, OFF_IMC: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    endfunction

    // Integration-test register check
    function automatic logic addr_itest(input logic [ADDR_W-1:0] a);
        addr_itest = addr_ok(a) && a != OFF_SPC && a != OFF_IMC;
    endfunction

    // Data capture: bit 0, then the top bit of every byte
    function automatic logic [DCAP_W-1:0] dcap(input logic [ATB_DATA_W-1:0] d);
        dcap[0] = d[0];
        for (int k = 1; k < DCAP_W; k++) begin
            dcap[k] = d[8*k-1];                                // R15
        end
    endfunction

    // ----------------------------------------
    // Counter hookup
    // ----------------------------------------
    assign sif.capture_en = trace_capture_en;
    assign sif.code = st_r.code;
    assign sif.bytes = byte_store_cnt;

    tbs_sync_cnt tbs_sync_cnt_inst (
        .pclk(pclk),
        .presetn(presetn),
        .sif(sif)
    );

    // ----------------------------------------
    // Combinational next state
    // ----------------------------------------
    logic acc_first;               // First access cycle: compute answer
    logic acc_done;                // Completing edge: commit effects
    logic fmt_on;                  // Formatting active
    logic trig_edge;
    logic flush_edge;
    logic [DATA_W-1:0] rd_val;

    assign acc_first = psel && penable && !st_r.pready;
    assign acc_done = psel && penable && st_r.pready;
    assign fmt_on = formatter_en || trigger_insert_en;         // R20
    // Edge detect looks only at the second sync stage
    assign trig_edge = st_r.trig_s[1] && !st_r.trig_s[2];
    assign flush_edge = st_r.flush_s[1] && !st_r.flush_s[2];

    // Read mux
    always_comb begin
        rd_val = '0;
        unique case (paddr)
            OFF_SPC: begin
                // Programmed values only, never the live count
                rd_val[SPC_FSI_BIT] = st_r.fsi;                // R7
                rd_val[CODE_W-1:0] = st_r.code;
            end
            OFF_IMC: begin
                rd_val[IMC_EN] = st_r.itmode;
            end
            OFF_TFIN: begin
                if (st_r.itmode) begin
                    rd_val[1:0] = st_r.tfin;
                end
            end
            OFF_DATA: begin
                if (st_r.itmode) begin
                    rd_val[DCAP_W-1:0] = dcap(atdata_s);       // R15 R18
                end
            end
            OFF_ID: begin
                if (st_r.itmode) begin
                    rd_val[ATID_W-1:0] = atid_s;               // R16 R18
                end
            end
            OFF_ATBI: begin
                if (st_r.itmode) begin                         // R17 R18
                    rd_val[ATBI_BYTES_LSB +: ATB_BYTES_W] = atbytes_s;
                    rd_val[ATBI_WAKEUP] = atwakeup_s;
                    rd_val[ATBI_AFREADY] = afready_s;
                    rd_val[ATBI_ATVALID] = atvalid_s;
                end
            end
            // Write-only test registers and unmapped read zero
            default: rd_val = '0;                              // R10
        endcase
    end

    // Register updates, sticky flags, outputs
    always_comb begin
        st_nxt = st_r;

        // Two-stage synchronisers plus history flop
        st_nxt.trig_s = {st_r.trig_s[1:0], trigin};
        st_nxt.flush_s = {st_r.flush_s[1:0], flushin};

        // APB: one wait state, answer registered
        st_nxt.pready = acc_first;
        st_nxt.pslverr = acc_first && !addr_ok(paddr);
        st_nxt.prdata = (acc_first && !pwrite) ? rd_val : '0;

        // Writes land on the completing edge only
        if (acc_done && pwrite) begin
            unique case (paddr)
                OFF_SPC: begin
                    st_nxt.code = tbs_legal_code(pwdata[CODE_W-1:0]); // R4 R5
                    st_nxt.fsi = pwdata[SPC_FSI_BIT];
                end
                OFF_IMC: begin
                    st_nxt.itmode = pwdata[IMC_EN];            // R19
                end
                OFF_EVT: begin
                    if (st_r.itmode) begin                     // R10
                        st_nxt.evt = pwdata[3:0];              // R11
                    end
                end
                OFF_ATBO: begin
                    if (st_r.itmode) begin                     // R10
                        st_nxt.atbo = pwdata[2:0];             // R12
                    end
                end
                // Capture registers and unmapped: ignored
                default: st_nxt.code = st_r.code;              // R18
            endcase
        end

        // Clear only the bits that were actually returned, so an edge
        // arriving between answer and commit is not lost
        if (acc_done && !pwrite && paddr == OFF_TFIN) begin
            st_nxt.tfin = st_r.tfin & ~st_r.prdata[1:0];       // R14
        end

        // Set wins over read-clear; leaving the mode clears
        if (st_r.itmode) begin
            st_nxt.tfin[TFIN_FLUSH] = st_nxt.tfin[TFIN_FLUSH] | flush_edge; // R13
            st_nxt.tfin[TFIN_TRIG] = st_nxt.tfin[TFIN_TRIG] | trig_edge;    // R13
        end else begin
            st_nxt.tfin = '0;                                  // R14
        end

        // Output flops: test values take over in integration mode
        if (st_nxt.itmode) begin
            st_nxt.syncreq = st_nxt.atbo[ATBO_SYNCREQ];        // R12
            st_nxt.afvalid = st_nxt.atbo[ATBO_AFVALID];
            st_nxt.atready = st_nxt.atbo[ATBO_ATREADY];
            st_nxt.evt_out = st_nxt.evt;                       // R11
        end else begin
            st_nxt.syncreq = sif.expire;                       // R2
            st_nxt.afvalid = func_afvalid;
            st_nxt.atready = func_atready;
            st_nxt.evt_out = func_evt;
        end

        // Frame sync only when formatting; bypass ignores the bit
        st_nxt.frame_sync = sif.expire && st_r.fsi && fmt_on;  // R8 R9
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= ST_RST;                                    // R6
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------
    // Outputs, all straight from flops
    // ----------------------------------------
    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign syncreq_s = st_r.syncreq;
    assign afvalid_s = st_r.afvalid;
    assign atready_s = st_r.atready;
    assign bufintr = st_r.evt_out[EVT_BUFINTR];
    assign flushcomp = st_r.evt_out[EVT_FLUSHCOMP];
    assign full = st_r.evt_out[EVT_FULL];
    assign acqcomp = st_r.evt_out[EVT_ACQCOMP];
    assign frame_sync_req = st_r.frame_sync;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    code_legal_a: assert property ( // R5
        st_r.code == CODE_OFF || (st_r.code >= CODE_MIN && st_r.code <= CODE_MAX))
        else $error("stored period code is reserved");

    sync_request_a: assert property ( // R2
        (sif.expire && !st_r.itmode && !(acc_done && pwrite)) |=> syncreq_s)
        else $error("expiry did not raise sync request");

    frame_insert_a: assert property ( // R8
        frame_sync_req |-> $past(sif.expire) && $past(st_r.fsi) && $past(fmt_on))
        else $error("frame sync without expiry, embed bit and formatting");

    itest_raz_a: assert property ( // R10
        (acc_done && !pwrite && addr_itest(paddr) && !st_r.itmode) |-> prdata == '0)
        else $error("test register not zero outside integration mode");

    evt_drive_a: assert property ( // R11
        (acc_done && pwrite && paddr == OFF_EVT && st_r.itmode)
        |=> {bufintr, flushcomp, full, acqcomp} == $past(pwdata[3:0]))
        else $error("event outputs not driven by written value");

    flag_set_a: assert property ( // R13
        (st_r.itmode && trig_edge) |=> st_r.tfin[TFIN_TRIG] || !st_r.itmode)
        else $error("trigger edge not latched");

    flag_exit_a: assert property ( // R14
        $fell(st_r.itmode) |=> st_r.tfin == '0)
        else $error("sticky bits survived leaving integration mode");

    period_read_a: assert property ( // R7
        (acc_first && !pwrite && paddr == OFF_SPC)
        |=> prdata == {26'h0, $past(st_r.fsi), $past(st_r.code)} && pready)
        else $error("period register read wrong");

    apb_answer_a: assert property (
        acc_first |=> pready ##1 !pready)
        else $error("answer not one cycle after access start");

    sync_req_c: cover property (!st_r.itmode && syncreq_s);
    frame_sync_c: cover property (frame_sync_req);
    flag_read_c: cover property (acc_done && paddr == OFF_TFIN && prdata != '0);
    itmode_c: cover property ($rose(st_r.itmode) ##[1:20] $fell(st_r.itmode));

endmodule // tbs_regs

// ===== dv/tbs_atb_src.sv
/*
 * Upstream trace source model on the ATB slave port.
 * Assumes the bench chooses the beat and controls it presents.
 */
`timescale 1ns/100ps
module tbs_atb_src
    import tbs_pkg::*;
(
    input wire logic pclk,
    input wire logic [ATB_DATA_W-1:0] beat,
    input wire logic [ATID_W-1:0] id,
    input wire logic [ATB_BYTES_W-1:0] nbytes,
    input wire logic valid,
    input wire logic wake,
    input wire logic afvalid_s,
    input wire logic syncreq_s,
    output logic [ATB_DATA_W-1:0] atdata_s,
    output logic [ATID_W-1:0] atid_s,
    output logic [ATB_BYTES_W-1:0] atbytes_s,
    output logic atvalid_s,
    output logic afready_s,
    output logic atwakeup_s
);
    int cyc = 0; // Free cycle count
    int sync_q[$]; // Cycles at which a sync request was seen
    initial atdata_s = '0;
    // ----------------------------------------
    // Beat presentation and request log
    // ----------------------------------------
    // Idle data toggles each cycle, so a stale beat reappears on every second idle cycle
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        atdata_s <= valid ? beat : ~atdata_s;
        atid_s <= id;
        atbytes_s <= nbytes;
        atvalid_s <= valid;
        atwakeup_s <= wake;
        afready_s <= afvalid_s; // Prompt flush ack
        if (syncreq_s === 1'b1) begin
            sync_q.push_back(cyc);
        end
    end
endmodule // tbs_atb_src

// ===== dv/tbs_regs_tb_top.sv
/*
 * Self-checking bench for the sync counter and integration test registers.
 * Assumes tbs_regs as the block and the source model on its ATB port.
 */
`timescale 1ns/100ps
module tbs_regs_tb_top;
    import tbs_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, frame_sync_req, atready_s, afvalid_s, syncreq_s;
    logic cap_en = 0, fmt_en = 0, ti_en = 0, trigin = 0, flushin = 0, valid = 1, wake = 0;
    logic [BCNT_W-1:0] nb = '0;
    logic [3:0] evt; // {bufintr, flushcomp, full, acqcomp}
    logic [ATB_DATA_W-1:0] beat = '0, atdata_s;
    logic [ATID_W-1:0] id = '0, atid_s;
    logic [ATB_BYTES_W-1:0] nbytes = '0, atbytes_s;
    logic atvalid_s, afready_s, atwakeup_s;
    int n_fail = 0, cmp_count = 0, cyc = 0, fs_n = 0;

    tbs_regs tbs_regs_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .trace_capture_en(cap_en), .formatter_en(fmt_en),
        .trigger_insert_en(ti_en), .byte_store_cnt(nb), .frame_sync_req,
        .func_atready(1'b0), .func_afvalid(1'b0), .func_evt(4'h5), .atdata_s, .atid_s,
        .atbytes_s, .atvalid_s, .afready_s, .atwakeup_s, .atready_s, .afvalid_s, .syncreq_s,
        .trigin, .flushin, .bufintr(evt[3]), .flushcomp(evt[2]), .full(evt[1]),
        .acqcomp(evt[0]));
    tbs_atb_src tbs_atb_src_inst (.pclk, .beat, .id, .nbytes, .valid, .wake, .afvalid_s,
        .syncreq_s, .atdata_s, .atid_s, .atbytes_s, .atvalid_s, .afready_s, .atwakeup_s);

    // ----------------------------------------
    // Clock, frame sync log and hang guard
    // ----------------------------------------
    initial begin
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (frame_sync_req === 1'b1) begin
            fs_n <= fs_n + 1;
        end
        if (cyc == 20000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        // Ends once pready is seen high; the bench hang guard catches a missing answer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic rd_is(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        apb(0, a, '0);
        chk(rd, exp);
    endtask
    task automatic settle;
        @(posedge pclk);
        @(negedge pclk);
    endtask
    task automatic wait_syncs(input int n);
        int i = 0;
        while (tbs_atb_src_inst.sync_q.size() < n && i < 3000) begin
            @(posedge pclk);
            i++;
        end
        // One more edge so the frame sync tally has settled
        @(posedge pclk);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        rd_is(OFF_SPC, SPC_RST);
        id <= 7'h55;
        apb(1, OFF_EVT, 32'h0000000F);
        settle;
        chk({28'h0, evt}, 32'h5);
        rd_is(OFF_ID, 32'h0);
        apb(0, 12'h100, '0);
        chk({31'h0, err}, 32'h1);
        $display("t_reset done");
    endtask
    task automatic t_codes;
        logic [4:0] c [7] = '{5'h01, 5'h06, 5'h1C, 5'h1F, 5'h07, 5'h1B, 5'h00};
        for (int i = 0; i < 7; i++) begin
            apb(1, OFF_SPC, {27'h0, c[i]});
            rd_is(OFF_SPC, {27'h0, (i < 4) ? CODE_MAX : c[i]});
        end
        $display("t_codes done");
    endtask
    task automatic t_sync;
        int s0, f0;
        apb(1, OFF_SPC, 32'h00000027);
        fmt_en <= 1;
        nb <= 5'h01;
        s0 = cyc;
        cap_en <= 1;
        wait_syncs(1);
        // Period changes mid-count; the old one must still finish
        apb(1, OFF_SPC, 32'h00000028);
        wait_syncs(3);
        chk(32'(tbs_atb_src_inst.sync_q[0] - s0 inside {[129:133]}), 32'h1);
        chk(tbs_atb_src_inst.sync_q[1] - tbs_atb_src_inst.sync_q[0], 128);
        chk(tbs_atb_src_inst.sync_q[2] - tbs_atb_src_inst.sync_q[1], 256);
        chk(fs_n, 3);
        fmt_en <= 0;
        ti_en <= 1;
        wait_syncs(4);
        chk(fs_n, 4);
        ti_en <= 0;
        wait_syncs(5);
        chk(fs_n, 4);
        apb(1, OFF_SPC, 32'h0);
        repeat (300) @(posedge pclk);
        f0 = tbs_atb_src_inst.sync_q.size();
        repeat (600) @(posedge pclk);
        chk(tbs_atb_src_inst.sync_q.size(), f0);
        cap_en <= 0;
        $display("t_sync done");
    endtask
    task automatic t_integ;
        logic [DATA_W-1:0] e = '0;
        beat <= 128'h8123_45F6_7089_AB0C_DEF1_0293_8475_6A9B;
        id <= 7'h5A;
        nbytes <= 4'hC;
        wake <= 1;
        apb(1, OFF_IMC, 32'h1);
        apb(1, OFF_EVT, 32'h0000000A);
        settle;
        chk({28'h0, evt}, 32'h0000000A);
        rd_is(OFF_EVT, 32'h0);
        apb(1, OFF_ATBO, 32'h7);
        settle;
        chk({29'h0, syncreq_s, afvalid_s, atready_s}, 32'h7);
        rd_is(OFF_ATBI, {20'h0, nbytes, 5'h0, wake, 1'b1, valid});
        e[0] = beat[0];
        for (int k = 1; k <= 16; k++) e[k] = beat[8*k-1];
        apb(1, OFF_DATA, 32'hFFFFFFFF);
        rd_is(OFF_DATA, e);
        apb(1, OFF_ID, 32'h7F);
        rd_is(OFF_ID, {25'h0, id});
        apb(1, OFF_ATBO, 32'h0);
        trigin <= 1;
        repeat (6) @(posedge pclk);
        trigin <= 0;
        rd_is(OFF_TFIN, 32'h1);
        rd_is(OFF_TFIN, 32'h0);
        flushin <= 1;
        repeat (6) @(posedge pclk);
        rd_is(OFF_TFIN, 32'h2);
        flushin <= 0;
        repeat (6) @(posedge pclk);
        flushin <= 1;
        repeat (6) @(posedge pclk);
        apb(1, OFF_IMC, 32'h0);
        apb(1, OFF_IMC, 32'h1);
        rd_is(OFF_TFIN, 32'h0);
        apb(1, OFF_IMC, 32'h0);
        rd_is(OFF_ATBI, 32'h0);
        $display("t_integ done");
    endtask

    task automatic tally_and_finish;
        $display("Counts: %0d compares, %0d mismatches", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1;
        t_reset;
        t_codes;
        t_sync;
        t_integ;
        tally_and_finish;
    end
endmodule // tbs_regs_tb_top
